// >>> verilog/dcsm_defines.vh
`ifndef DCSM_DEFINES_VH
`define DCSM_DEFINES_VH

// avalon register word addresses (word index on a 4-bit word address)
`define DCSM_ADDR_SEL        4'h0
`define DCSM_ADDR_FORMAT     4'h1
`define DCSM_ADDR_JOG1       4'h2
`define DCSM_ADDR_JOG2       4'h3
`define DCSM_ADDR_GAP        4'h4
`define DCSM_ADDR_REACT      4'h5
`define DCSM_ADDR_STATUS     4'h6
`define DCSM_ADDR_SERIAL     4'h7

// selector field positions inside the selector register
`define DCSM_SEL_DIR_LSB     0
`define DCSM_SEL_SET_LSB     2
`define DCSM_SEL_PRE_LSB     4

// merge modes
`define DCSM_MODE_TERM       2'h0
`define DCSM_MODE_SER        2'h1
`define DCSM_MODE_AND        2'h2
`define DCSM_MODE_OR         2'h3

// reset values and legal limits
`define DCSM_SEL_RST         6'h3f
`define DCSM_FORMAT_RST      1'h1
`define DCSM_JOG_RST         16'h0064
`define DCSM_GAP_RST         7'h01
`define DCSM_GAP_MIN         7'h01
`define DCSM_GAP_MAX         7'h63
`define DCSM_REACT_RST       3'h0
`define DCSM_REACT_MAX       3'h5

// silence reactions
`define DCSM_REACT_OFF       3'h0
`define DCSM_REACT_FREEZE    3'h1
`define DCSM_REACT_STOP      3'h2
`define DCSM_REACT_JOG       3'h3
`define DCSM_REACT_MAXSPD    3'h4
`define DCSM_REACT_TRIP      3'h5

// timing
`define DCSM_CLK_HZ          20000000
`define DCSM_TICK_S          1
`define DCSM_TICK_CYCLES     (`DCSM_CLK_HZ * `DCSM_TICK_S)

`endif

// >>> verilog/dcsm_sync.v
`timescale 1ns/10ps
`default_nettype none

// two-flop synchroniser for a group of pin inputs
module dcsm_sync #(
  parameter W = 1
) (
  input  wire         ref_clk_i,
  input  wire         nrst_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

`default_nettype wire

// >>> verilog/dcsm_gap_timer.v
`timescale 1ns/10ps
`default_nettype none
`include "dcsm_defines.vh"

// telegram gap watchdog counting one-second ticks
module dcsm_gap_timer #(
  parameter [31:0] TICK_CYCLES = `DCSM_TICK_CYCLES
) (
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  input  wire       telegram_i,
  input  wire [6:0] limit_i,
  output reg        loss_o,
  output reg        lost_o,
  output reg  [6:0] seconds_o
);

  reg [31:0] div_reg;
  wire       tick;

  assign tick = (div_reg == TICK_CYCLES - 32'h1);

  // divider restarts with each telegram so a full limit always elapses
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_reg <= 32'h0;
    end else if (telegram_i || tick) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= div_reg + 32'h1;
    end
  end

  // second counter, single loss pulse when the limit is reached
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seconds_o <= 7'h0;
      loss_o    <= 1'b0;
      lost_o    <= 1'b0;
    end else begin
      loss_o <= 1'b0;
      if (telegram_i) begin
        seconds_o <= 7'h0; // [RQ14]
        lost_o    <= 1'b0;
      end else if (tick && !lost_o) begin
        if (seconds_o + 7'h1 >= limit_i) begin
          loss_o <= 1'b1; // [RQ14]
          lost_o <= 1'b1; // [RQ12]
        end
        seconds_o <= seconds_o + 7'h1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> verilog/dcsm_top.v
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "dcsm_defines.vh"

// Overview of operation
// [RQ1] direction follows the terminal input in mode 0 and the serial bit in mode 1, 1 meaning anti-clockwise.
// [RQ2] direction mode 2 needs both sources at 1 for anti-clockwise, mode 3 needs either.
// [RQ3] the parameter set is the two-bit code plus one, from terminal pair in mode 0 and serial pair in mode 1.
// [RQ4] set mode 2 ands the serial and terminal pairs bit by bit before adding one.
// [RQ5] set mode 3, the reset default, ors the pairs bit by bit before adding one.
// [RQ6] the preset reference has the same four merge modes and resets to the or mode.
// [RQ7] serial preset-reference bits count only while the native control format is chosen.
// [RQ8] with the fieldbus format the serial master may pick one of two jog speeds.
// [RQ9] both serial jog speeds range from 0 to the maximum frequency and reset to 10.0 Hz.
// [RQ10] a one-bit format selector picks fieldbus profile at 0 and native profile at 1, the default.
// [RQ11] the telegram gap limit ranges 1 to 99 seconds and resets to 1 second.
// [RQ12] the master must send within the gap limit, otherwise the link is lost and the reaction applies.
// [RQ13] the silence reaction is off, freeze, stop, jog, max speed or trip, and any of 1 to 5 drops the relay.
// [RQ14] every good telegram restarts the gap timer, which counts seconds and pulses once on loss.
// [RQ15] all merged selector outputs are registered on the system clock.
module dcsm_top #(
  parameter [31:0] TICK_CYCLES = `DCSM_TICK_CYCLES
) (
  input  wire        ref_clk_i,
  input  wire        nrst_i,
  // avalon-mm slave
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // terminal inputs (pins)
  input  wire        term_reverse_i,
  input  wire [1:0]  term_set_i,
  input  wire [1:0]  term_preset_i,
  // serial receiver side, same clock
  input  wire        telegram_ok_i,
  input  wire        ser_reverse_i,
  input  wire [1:0]  ser_set_i,
  input  wire [1:0]  ser_preset_i,
  input  wire        ser_jog_one_i,
  input  wire        ser_jog_two_i,
  // merged outputs
  output reg         reverse_o,
  output reg  [2:0]  active_set_o,
  output reg  [1:0]  preset_ref_o,
  output reg         native_control_format_o,
  output reg         jog_req_o,
  output reg  [15:0] jog_speed_o,
  output reg         link_lost_o,
  output reg         link_loss_pulse_o,
  output reg  [2:0]  link_silence_reaction_o,
  output reg         relay_drop_o
);

  // merge one bit by mode
  function merge_bit;
    input [1:0] mode;
    input       term;
    input       ser;
    begin
      case (mode)
        `DCSM_MODE_TERM: merge_bit = term;
        `DCSM_MODE_SER:  merge_bit = ser;
        `DCSM_MODE_AND:  merge_bit = term & ser;
        default:         merge_bit = term | ser;
      endcase
    end
  endfunction

  // clamp a gap limit into its legal range
  function [6:0] clamp_gap;
    input [6:0] v;
    begin
      if (v < `DCSM_GAP_MIN) begin
        clamp_gap = `DCSM_GAP_MIN;
      end else if (v > `DCSM_GAP_MAX) begin
        clamp_gap = `DCSM_GAP_MAX;
      end else begin
        clamp_gap = v;
      end
    end
  endfunction

  reg  [5:0]  sel_reg;
  reg         format_reg;
  reg  [15:0] jog1_reg;
  reg  [15:0] jog2_reg;
  reg  [6:0]  gap_reg;
  reg  [2:0]  react_reg;
  reg  [15:0] max_freq_reg;
  reg         wait_reg;

  wire [4:0]  term_sync;
  wire        loss_pulse;
  wire        lost;
  wire [6:0]  seconds;
  wire [1:0]  dir_mode;
  wire [1:0]  set_mode;
  wire [1:0]  pre_mode;
  wire [1:0]  ser_pre_eff;
  wire        wr_req;
  wire        rd_req;

  // terminal pins come from outside the clock domain
  dcsm_sync #(
    .W (5)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .async_i   ({term_reverse_i, term_set_i, term_preset_i}),
    .sync_o    (term_sync)
  );

  dcsm_gap_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_gap (
    .ref_clk_i  (ref_clk_i),
    .nrst_i     (nrst_i),
    .telegram_i (telegram_ok_i),
    .limit_i    (gap_reg),
    .loss_o     (loss_pulse),
    .lost_o     (lost),
    .seconds_o  (seconds)
  );

  assign dir_mode = sel_reg[`DCSM_SEL_DIR_LSB+1:`DCSM_SEL_DIR_LSB];
  assign set_mode = sel_reg[`DCSM_SEL_SET_LSB+1:`DCSM_SEL_SET_LSB];
  assign pre_mode = sel_reg[`DCSM_SEL_PRE_LSB+1:`DCSM_SEL_PRE_LSB];

  // serial preset bits are blanked outside the native format
  assign ser_pre_eff = format_reg ? ser_preset_i : 2'h0; // [RQ7]

  // one wait cycle per access; read data is latched in the wait cycle so it stands when waitrequest drops
  assign wr_req            = avs_write_i && wait_reg;
  assign rd_req            = avs_read_i && !wait_reg;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !wait_reg;

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= (avs_read_i || avs_write_i) && !wait_reg;
    end
  end

  // register writes; low byte lanes carry the fields, upper lanes carry max_freq_reg in the format word
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_reg      <= `DCSM_SEL_RST; // [RQ5] [RQ6]
      format_reg   <= `DCSM_FORMAT_RST; // [RQ10]
      jog1_reg     <= `DCSM_JOG_RST; // [RQ9]
      jog2_reg     <= `DCSM_JOG_RST;
      gap_reg      <= `DCSM_GAP_RST; // [RQ11]
      react_reg    <= `DCSM_REACT_RST;
      max_freq_reg <= 16'hffff;
    end else if (wr_req) begin
      case (avs_address_i)
        `DCSM_ADDR_SEL: begin
          if (avs_byteenable_i[0]) sel_reg <= avs_writedata_i[5:0];
        end
        `DCSM_ADDR_FORMAT: begin
          if (avs_byteenable_i[0]) format_reg <= avs_writedata_i[0];
          if (avs_byteenable_i[2] && avs_byteenable_i[3]) max_freq_reg <= avs_writedata_i[31:16];
        end
        `DCSM_ADDR_JOG1: begin
          // values beyond the max frequency saturate [RQ9]
          if (avs_byteenable_i[1:0] == 2'h3) begin
            jog1_reg <= (avs_writedata_i[15:0] > max_freq_reg) ? max_freq_reg : avs_writedata_i[15:0];
          end
        end
        `DCSM_ADDR_JOG2: begin
          if (avs_byteenable_i[1:0] == 2'h3) begin
            jog2_reg <= (avs_writedata_i[15:0] > max_freq_reg) ? max_freq_reg : avs_writedata_i[15:0];
          end
        end
        `DCSM_ADDR_GAP: begin
          if (avs_byteenable_i[0]) gap_reg <= clamp_gap(avs_writedata_i[6:0]); // [RQ11]
        end
        `DCSM_ADDR_REACT: begin
          // out-of-range reactions are ignored
          if (avs_byteenable_i[0] && avs_writedata_i[2:0] <= `DCSM_REACT_MAX) begin
            react_reg <= avs_writedata_i[2:0]; // [RQ13]
          end
        end
        default: begin
        end
      endcase
    end
  end

  // read mux; unmapped words read zero
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (rd_req) begin
      case (avs_address_i)
        `DCSM_ADDR_SEL:     avs_readdata_o <= {26'h0, sel_reg};
        `DCSM_ADDR_FORMAT:  avs_readdata_o <= {max_freq_reg, 15'h0, format_reg};
        `DCSM_ADDR_JOG1:    avs_readdata_o <= {16'h0, jog1_reg};
        `DCSM_ADDR_JOG2:    avs_readdata_o <= {16'h0, jog2_reg};
        `DCSM_ADDR_GAP:     avs_readdata_o <= {25'h0, gap_reg};
        `DCSM_ADDR_REACT:   avs_readdata_o <= {29'h0, react_reg};
        `DCSM_ADDR_STATUS:  avs_readdata_o <= {16'h0, seconds, 7'h0, relay_drop_o, link_lost_o};
        `DCSM_ADDR_SERIAL:  avs_readdata_o <= {24'h0, active_set_o, preset_ref_o, reverse_o, 2'h0};
        default:            avs_readdata_o <= 32'h0;
      endcase
    end
  end

  // merged selectors, registered so outputs move only on edges
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reverse_o    <= 1'b0;
      active_set_o <= 3'h1;
      preset_ref_o <= 2'h0;
    end else begin
      reverse_o    <= merge_bit(dir_mode, term_sync[4], ser_reverse_i); // [RQ1] [RQ2] [RQ15]
      active_set_o <= {1'b0, merge_bit(set_mode, term_sync[3], ser_set_i[1]),
                       merge_bit(set_mode, term_sync[2], ser_set_i[0])} + 3'h1; // [RQ3] [RQ4] [RQ5] [RQ15]
      preset_ref_o <= {merge_bit(pre_mode, term_sync[1], ser_pre_eff[1]),
                       merge_bit(pre_mode, term_sync[0], ser_pre_eff[0])}; // [RQ6] [RQ15]
    end
  end

  // jog selection only in the fieldbus format; jog one wins a tie
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      native_control_format_o <= `DCSM_FORMAT_RST;
      jog_req_o               <= 1'b0;
      jog_speed_o             <= 16'h0;
    end else begin
      native_control_format_o <= format_reg; // [RQ10]
      jog_req_o               <= !format_reg && (ser_jog_one_i || ser_jog_two_i); // [RQ8]
      if (!format_reg && ser_jog_one_i) begin
        jog_speed_o <= jog1_reg; // [RQ8]
      end else if (!format_reg && ser_jog_two_i) begin
        jog_speed_o <= jog2_reg;
      end else begin
        jog_speed_o <= 16'h0;
      end
    end
  end

  // silence reaction; held until a telegram arrives again
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_lost_o             <= 1'b0;
      link_loss_pulse_o       <= 1'b0;
      link_silence_reaction_o <= `DCSM_REACT_OFF;
      relay_drop_o            <= 1'b0;
    end else begin
      link_lost_o             <= lost; // [RQ12]
      link_loss_pulse_o       <= loss_pulse;
      link_silence_reaction_o <= lost ? react_reg : `DCSM_REACT_OFF; // [RQ13]
      relay_drop_o            <= lost && (react_reg != `DCSM_REACT_OFF); // [RQ13]
    end
  end

endmodule

`default_nettype wire

// >>> verif/dcsm_partner.sv
`timescale 1ns/10ps
`default_nettype none
// serial master stand-in: one good telegram every 8 cycles while enabled
module dcsm_partner (
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic send_en_i,
  output var  logic telegram_o
);
  logic [2:0] cnt_reg;

  // period kept well inside the shortest gap limit in the bench
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 3'h0;
      telegram_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      telegram_o <= send_en_i && (cnt_reg == 3'h0);
    end
  end
endmodule
`default_nettype wire

// >>> verif/dcsm_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the merge block
module dcsm_top_sva #(
  parameter [31:0] TICK_CYCLES = 32'h14
) (
  input wire logic       ref_clk_i,
  input wire logic       nrst_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  input wire logic       telegram_ok_i,
  input wire logic [2:0] active_set_o,
  input wire logic       native_control_format_o,
  input wire logic       jog_req_o,
  input wire logic[15:0] jog_speed_o,
  input wire logic       link_lost_o,
  input wire logic       link_loss_pulse_o,
  input wire logic [2:0] link_silence_reaction_o,
  input wire logic       relay_drop_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // a request always costs exactly one wait cycle
  sequence s_req;
    $rose(avs_read_i || avs_write_i);
  endsequence
  sequence s_one_wait;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  AST_WAIT_ONE: assert property (s_req |-> s_one_wait) else $error("wait not one cycle");
  AST_WAIT_IDLE: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("wait while idle");
  AST_SET_RANGE: assert property (active_set_o >= 3'h1 && active_set_o <= 3'h4)
    else $error("set out of range");
  AST_PULSE_ONE: assert property (link_loss_pulse_o |=> !link_loss_pulse_o)
    else $error("loss pulse too long");
  AST_LOST_FOLLOWS: assert property (link_loss_pulse_o |=> link_lost_o)
    else $error("lost not raised");
  AST_LOST_CAUSE: assert property ($rose(link_lost_o) |-> link_loss_pulse_o)
    else $error("lost without pulse");
  AST_TEL_CLEARS: assert property (telegram_ok_i |-> ##[1:2] !link_lost_o)
    else $error("telegram did not clear");
  AST_NO_EARLY: assert property (telegram_ok_i |=> !link_loss_pulse_o [*8])
    else $error("loss soon after telegram");
  AST_RELAY: assert property (relay_drop_o |-> link_lost_o && link_silence_reaction_o != 3'h0)
    else $error("relay drop without reaction");
  AST_JOG_FMT: assert property (jog_req_o |-> !native_control_format_o)
    else $error("jog in native format");
  AST_JOG_ZERO: assert property (!jog_req_o |-> jog_speed_o == 16'h0)
    else $error("jog speed without jog");
endmodule
bind dcsm_top dcsm_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.ref_clk_i, .nrst_i, .avs_read_i,
  .avs_write_i, .avs_waitrequest_o, .telegram_ok_i, .active_set_o, .native_control_format_o,
  .jog_req_o, .jog_speed_o, .link_lost_o, .link_loss_pulse_o, .link_silence_reaction_o, .relay_drop_o);
`default_nettype wire

// >>> verif/tb_drive_command_source_merge.sv
`timescale 1ns/10ps
`default_nettype none
module tb_drive_command_source_merge;
  localparam int TK = 20;
  logic        ref_clk_i, nrst_i, rd, wr, wreq, tel, ten, trev, srev, rev, nat, jreq, j1, j2, lost, lpls, relay;
  logic [3:0]  adr;
  logic [31:0] wd, rdata, q;
  logic [1:0]  tset, sset, tpre, spre, pre, e;
  logic [2:0]  aset, react;
  logic [15:0] jspd;
  int          n_mismatch = 0, checked = 0, gcnt = 0, n, lim;
  logic [31:0] rv [6] = '{32'h3f, 32'hffff0001, 32'h64, 32'h64, 32'h1, 32'h0};

  dcsm_top #(.TICK_CYCLES(32'h14)) dut (.ref_clk_i, .nrst_i, .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .term_reverse_i(trev), .term_set_i(tset), .term_preset_i(tpre),
    .telegram_ok_i(tel), .ser_reverse_i(srev), .ser_set_i(sset), .ser_preset_i(spre), .ser_jog_one_i(j1),
    .ser_jog_two_i(j2), .reverse_o(rev), .active_set_o(aset), .preset_ref_o(pre), .native_control_format_o(nat),
    .jog_req_o(jreq), .jog_speed_o(jspd), .link_lost_o(lost), .link_loss_pulse_o(lpls),
    .link_silence_reaction_o(react), .relay_drop_o(relay));
  dcsm_partner u_part (.ref_clk_i, .nrst_i, .send_en_i(ten), .telegram_o(tel));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // cycles since the last telegram, to time the loss event
  always @(posedge ref_clk_i) gcnt <= tel ? 0 : gcnt + 1;

  task tally_and_finish;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, s, x);
    end
  endtask
  // one avalon transfer; held until the edge that samples waitrequest low, data taken there
  task av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge ref_clk_i);
    while (wreq !== 1'b0) @(posedge ref_clk_i);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rdk(input logic [3:0] a, input logic [31:0] x);
    av(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  // terminals need two sync flops plus the output register
  task settle;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  function automatic logic [1:0] mrg(input logic [1:0] m, input logic [1:0] a, input logic [1:0] b);
    case (m)
      2'h0: mrg = a;
      2'h1: mrg = b;
      2'h2: mrg = a & b;
      default: mrg = a | b;
    endcase
  endfunction

  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    {nrst_i, rd, wr, adr, wd, trev, tset, tpre, srev, sset, spre, j1, j2} = '0;
    ten = 1'b1;
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(negedge ref_clk_i);
    chk(aset, 32'h1);
    chk(nat, 32'h1);
    for (int i = 0; i < 6; i++) rdk(i[3:0], rv[i]);
    rdk(4'h8, 32'h0);
    rdk(4'h6, 32'h0);
    // every merge mode against every source combination
    for (int m = 0; m < 4; m++) begin
      av(1'b1, 4'h0, {26'h0, m[1:0], m[1:0], m[1:0]});
      for (int v = 0; v < 16; v++) begin
        @(posedge ref_clk_i);
        {trev, tset, tpre} <= {v[2], v[3:2], v[3:2]};
        {srev, sset, spre} <= {v[0], v[1:0], v[1:0]};
        settle;
        e = mrg(m[1:0], v[3:2], v[1:0]);
        chk(rev, e[0]);
        chk(aset, e + 3'h1);
        chk(pre, e);
      end
    end
    // fieldbus format: jog speeds, serial preset bits ignored
    av(1'b1, 4'h1, 32'hffff0000);
    av(1'b1, 4'h2, 32'h1f4);
    av(1'b1, 4'h3, 32'h0);
    @(posedge ref_clk_i);
    {j1, j2, tpre, spre} <= 6'h33;
    settle;
    chk(jreq, 32'h1);
    chk(jspd, 32'h1f4);
    chk(pre, 32'h0);
    chk(nat, 32'h0);
    @(posedge ref_clk_i);
    j1 <= 1'b0;
    settle;
    chk(jspd, 32'h0);
    av(1'b1, 4'h1, 32'h03e80000);
    av(1'b1, 4'h2, 32'h7d0);
    rdk(4'h2, 32'h3e8);
    av(1'b1, 4'h1, 32'h03e80001);
    settle;
    chk(jreq, 32'h0);
    chk(pre, 32'h3);
    av(1'b1, 4'h4, 32'h0);
    rdk(4'h4, 32'h1);
    av(1'b1, 4'h4, 32'h64);
    rdk(4'h4, 32'h63);
    // silence the master under each reaction
    for (int r = 0; r < 6; r++) begin
      lim = (r == 5) ? 2 : 1;
      av(1'b1, 4'h4, lim);
      av(1'b1, 4'h5, r);
      @(posedge ref_clk_i);
      ten <= 1'b0;
      n = 0;
      while (lpls !== 1'b1 && n < 200) begin
        n++;
        @(negedge ref_clk_i);
      end
      chk(gcnt >= lim * TK - 2 && gcnt <= lim * TK + 2, 32'h1);
      repeat (2) @(negedge ref_clk_i);
      chk(lost, 32'h1);
      chk(react, r);
      chk(relay, r != 0);
      @(posedge ref_clk_i);
      ten <= 1'b1;
      repeat (12) @(negedge ref_clk_i);
      chk(lost, 32'h0);
    end
    av(1'b1, 4'h5, 32'h6);
    rdk(4'h5, 32'h5);
    tally_and_finish;
  end
endmodule
`default_nettype wire
